// [rtl/flash_die_ctrl.sv]
`default_nettype none

module flash_die_ctrl #(
    parameter logic [7:0] DIE_ID = flash_cmd_pkg::FIRST_DIE
) (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       hw_reset_n_in,
    input  wire logic       sclk_in,
    input  wire logic       cs_n_in,
    input  wire logic       serial_in,
    input  wire logic       core_busy_in,
    input  wire logic       core_done_in,
    output logic            so_out,
    output logic            so_oe_out,
    output logic            die_active_out,
    output logic            write_enable_latch_out,
    output logic            busy_out,
    output logic            addr_4byte_out,
    output logic            ext_addr_used_out,
    output logic [7:0]      ext_addr_out,
    output logic [7:0]      status_1_out,
    output logic [7:0]      status_2_out,
    output logic [7:0]      status_3_out
);

    localparam int WSR_DLY = flash_cmd_pkg::WSR_CYCLES;
    localparam int CNT_W   = $clog2(flash_cmd_pkg::WSR_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LOAD =
        CNT_W'(flash_cmd_pkg::WSR_CYCLES);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    // Link side: everything here runs on the host's clock
    logic [2:0] phase_q;
    logic [1:0] bytes_q;
    logic [7:0] sh_q;
    logic [7:0] op_q;
    logic [7:0] byte1_q;
    logic [7:0] byte2_q;
    logic [4:0] len_q;
    logic       so_q;
    logic       oe_q;
    logic [7:0] sh_next;
    logic [2:0] phase_next;
    logic [1:0] bytes_next;

    // Snapshot published to the link side while no frame is open
    logic [7:0] snap1_q;
    logic [7:0] snap2_q;
    logic [7:0] snap3_q;
    logic [7:0] snap_ext_q;
    logic       snap_act_q;

    assign sh_next    = {sh_q[6:0], serial_in};
    assign phase_next = phase_q + 3'h1;
    assign bytes_next = (phase_q == flash_cmd_pkg::PHASE_LAST &&
                         bytes_q != flash_cmd_pkg::BYTES_MAX) ?
                        bytes_q + 2'h1 : bytes_q;

    // Bit position restarts with every frame; the clock may stop outside
    always_ff @(posedge sclk_in or posedge cs_n_in)
    begin
        if (cs_n_in)
        begin
            phase_q <= 3'h0;
            bytes_q <= 2'h0;
        end
        else
        begin
            phase_q <= phase_next;
            bytes_q <= bytes_next;
        end
    end

    // Frame contents outlive the frame so the system side can read them
    always_ff @(posedge sclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            sh_q    <= 8'h00;
            op_q    <= 8'h00;
            byte1_q <= 8'h00;
            byte2_q <= 8'h00;
            len_q   <= 5'h00;
        end
        else
        begin
            sh_q  <= sh_next;
            len_q <= {bytes_next, phase_next};
            if (phase_q == flash_cmd_pkg::PHASE_LAST && bytes_q == 2'h0)
                op_q <= sh_next;
            if (phase_q == flash_cmd_pkg::PHASE_LAST && bytes_q == 2'h1)
                byte1_q <= sh_next;
            if (phase_q == flash_cmd_pkg::PHASE_LAST && bytes_q == 2'h2)
                byte2_q <= sh_next;
        end
    end

    logic       rd_s1;
    logic       rd_s2;
    logic       rd_s3;
    logic       rd_ext;
    logic       rd_hit;
    logic [7:0] rd_byte;

    assign rd_s1   = op_q == flash_cmd_pkg::OP_RD_S1;
    assign rd_s2   = op_q == flash_cmd_pkg::OP_RD_S2;
    assign rd_s3   = op_q == flash_cmd_pkg::OP_RD_S3;
    assign rd_ext  = op_q == flash_cmd_pkg::OP_RD_EXT;
    // Only the active die may drive the shared output
    assign rd_hit  = snap_act_q && bytes_q != 2'h0 &&
                     (rd_s1 || rd_s2 || rd_s3 || rd_ext);
    assign rd_byte = rd_s1 ? snap1_q :
                     rd_s2 ? snap2_q :
                     rd_s3 ? snap3_q : snap_ext_q;

    // Falling edge shift, MSB first, wraps so the byte repeats
    always_ff @(negedge sclk_in or posedge cs_n_in)
    begin
        if (cs_n_in)
        begin
            so_q <= 1'b0;
            oe_q <= 1'b0;
        end
        else
        begin
            so_q <= rd_byte[~phase_q];
            oe_q <= rd_hit;
        end
    end

    assign so_out    = so_q;
    assign so_oe_out = oe_q;

    // System side
    logic          cs_s1_q;
    logic          cs_s2_q;
    logic          cs_s3_q;
    logic          hr_s1_q;
    logic          hr_s2_q;
    logic          frame_end;
    logic          hw_rst;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
            hr_s1_q <= 1'b1;
            hr_s2_q <= 1'b1;
        end
        else
        begin
            cs_s1_q <= cs_n_in;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
            hr_s1_q <= hw_reset_n_in;
            hr_s2_q <= hr_s1_q;
        end
    end

    // Frame fields are quiet by now: no clock edges while deselected
    assign frame_end = cs_s2_q && !cs_s3_q;
    assign hw_rst    = !hr_s2_q;

    flash_cmd_pkg::wsr_state_type state_q;
    flash_cmd_pkg::wsr_state_type state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic       active_q, active_d;
    logic       wel_q, wel_d;
    logic       vol_en_q, vol_en_d;
    logic       arm_q, arm_d;
    logic       addr4_q, addr4_d;
    logic [7:0] ext_q, ext_d;
    logic [7:0] nv1_q, nv1_d;
    logic [7:0] nv2_q, nv2_d;
    logic [7:0] nv3_q, nv3_d;
    logic [7:0] vol1_q, vol1_d;
    logic [7:0] vol2_q, vol2_d;
    logic [7:0] vol3_q, vol3_d;

    logic       cmd;
    logic       busy_wr;
    logic       can_write;
    logic       wr_s1, wr_s2, wr_s3, is_wsr, wsr_len_ok;
    logic       wsr_go, nv_go, vol_go, ext_go;
    logic       wren_hit, wrdis_hit, vol_hit, die_hit;
    logic       sw_rst, reset_any, wsr_end, addr_hit;
    logic [7:0] val2;
    logic [7:0] lock_nv, lock_vol;
    logic [7:0] rd1, rd3;

    function automatic logic [7:0] merge_bits(input logic [7:0] old_v,
                                              input logic [7:0] new_v,
                                              input logic [7:0] mask);
        return (old_v & ~mask) | (new_v & mask);
    endfunction : merge_bits

    assign cmd       = frame_end && active_q;
    assign busy_wr   = state_q == flash_cmd_pkg::ST_WRITING;
    assign can_write = !busy_wr && !core_busy_in;
    assign wr_s1     = op_q == flash_cmd_pkg::OP_WR_S1;
    assign wr_s2     = op_q == flash_cmd_pkg::OP_WR_S2 ||
                       (wr_s1 && len_q == flash_cmd_pkg::LEN_TWO);
    assign wr_s3     = op_q == flash_cmd_pkg::OP_WR_S3;
    assign is_wsr    = wr_s1 || wr_s2 || wr_s3;
    assign wsr_len_ok = len_q == flash_cmd_pkg::LEN_ONE ||
                        (wr_s1 && len_q == flash_cmd_pkg::LEN_TWO);
    // Without latch or volatile enable the write leaves no trace
    assign wsr_go    = cmd && is_wsr && wsr_len_ok && can_write &&
                       (wel_q || vol_en_q);
    assign nv_go     = wsr_go && wel_q;
    assign vol_go    = wsr_go && !wel_q;
    assign ext_go    = cmd && op_q == flash_cmd_pkg::OP_WR_EXT &&
                       len_q == flash_cmd_pkg::LEN_ONE && wel_q &&
                       can_write;
    assign wren_hit  = cmd && op_q == flash_cmd_pkg::OP_WR_EN &&
                       len_q == flash_cmd_pkg::LEN_OP;
    assign wrdis_hit = cmd && op_q == flash_cmd_pkg::OP_WR_DIS &&
                       len_q == flash_cmd_pkg::LEN_OP;
    assign vol_hit   = cmd && op_q == flash_cmd_pkg::OP_VOL_EN &&
                       len_q == flash_cmd_pkg::LEN_OP;
    // Every die listens to the select, active or not
    assign die_hit   = frame_end && op_q == flash_cmd_pkg::OP_DIE_SEL &&
                       len_q == flash_cmd_pkg::LEN_ONE;
    assign sw_rst    = cmd && arm_q && op_q == flash_cmd_pkg::OP_RST &&
                       len_q == flash_cmd_pkg::LEN_OP;
    assign reset_any = sw_rst || hw_rst;
    assign wsr_end   = busy_wr && cnt_q == CNT_ONE;
    assign addr_hit  = cmd && addr4_q && flash_cmd_pkg::is_addr_op(op_q) &&
                       len_q >= flash_cmd_pkg::LEN_ONE;
    assign val2      = wr_s1 ? byte2_q : byte1_q;
    assign lock_nv   = nv2_q & flash_cmd_pkg::S2_LOCK_MASK;
    assign lock_vol  = vol2_q & flash_cmd_pkg::S2_LOCK_MASK;

    // Writable fields only; locks can only be added
    assign nv1_d = (nv_go && wr_s1) ?
                   merge_bits(nv1_q, byte1_q, flash_cmd_pkg::S1_WMASK) :
                   nv1_q;
    assign nv2_d = (nv_go && wr_s2) ?
                   (merge_bits(nv2_q, val2, flash_cmd_pkg::S2_WMASK) |
                    lock_nv) :
                   (vol_go && wr_s2) ?
                   (nv2_q | (val2 & flash_cmd_pkg::S2_LOCK_MASK)) : nv2_q;
    assign nv3_d = (nv_go && wr_s3) ?
                   merge_bits(nv3_q, byte1_q, flash_cmd_pkg::S3_WMASK) :
                   nv3_q;

    // Reset drops volatile values and reloads stored ones
    assign vol1_d = reset_any ? nv1_q :
                    (wsr_go && wr_s1) ?
                    merge_bits(vol1_q, byte1_q, flash_cmd_pkg::S1_WMASK) :
                    vol1_q;
    assign vol2_d = reset_any ? nv2_q :
                    (wsr_go && wr_s2) ?
                    (merge_bits(vol2_q, val2, flash_cmd_pkg::S2_WMASK) |
                     lock_vol | lock_nv) : vol2_q;
    assign vol3_d = reset_any ? nv3_q :
                    (wsr_go && wr_s3) ?
                    merge_bits(vol3_q, byte1_q, flash_cmd_pkg::S3_WMASK) :
                    vol3_q;

    // Top address byte follows 4-byte traffic
    assign ext_d = reset_any ? flash_cmd_pkg::EXT_RESET :
                   ext_go ? byte1_q :
                   addr_hit ? byte1_q : ext_q;

    assign addr4_d = reset_any ? nv3_q[flash_cmd_pkg::S3_PWR_ADDR] :
                     (cmd && len_q == flash_cmd_pkg::LEN_OP &&
                      op_q == flash_cmd_pkg::OP_ADDR4_ON) ? 1'b1 :
                     (cmd && len_q == flash_cmd_pkg::LEN_OP &&
                      op_q == flash_cmd_pkg::OP_ADDR4_OFF) ? 1'b0 :
                     addr4_q;

    // A set wins over any clear arriving with it except a reset
    always_comb
    begin
        wel_d = wel_q;
        if (reset_any || wsr_end || core_done_in || wrdis_hit || vol_hit)
            wel_d = 1'b0;
        if (wren_hit && !reset_any)
            wel_d = 1'b1;
    end

    assign vol_en_d = reset_any ? 1'b0 :
                      vol_hit ? 1'b1 :
                      cmd ? 1'b0 : vol_en_q;
    assign arm_d    = reset_any ? 1'b0 :
                      cmd ? (op_q == flash_cmd_pkg::OP_RST_EN) : arm_q;
    assign active_d = die_hit ? (byte1_q == DIE_ID) : active_q;

    // Self-timed write; runs on even when this die is deselected
    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        unique case (state_q)
            flash_cmd_pkg::ST_IDLE:
            begin
                if (nv_go && !reset_any)
                begin
                    state_d = flash_cmd_pkg::ST_WRITING;
                    cnt_d   = CNT_LOAD;
                end
            end
            flash_cmd_pkg::ST_WRITING:
            begin
                cnt_d = cnt_q - CNT_ONE;
                if (wsr_end || hw_rst)
                    state_d = flash_cmd_pkg::ST_IDLE;
            end
            default:
            begin
                state_d = flash_cmd_pkg::ST_IDLE;
            end
        endcase
    end

    // Power-up defaults; die zero comes up active
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_q  <= flash_cmd_pkg::ST_IDLE;
            cnt_q    <= '0;
            active_q <= DIE_ID == flash_cmd_pkg::FIRST_DIE;
            wel_q    <= 1'b0;
            vol_en_q <= 1'b0;
            arm_q    <= 1'b0;
            addr4_q  <= 1'b0;
            ext_q    <= flash_cmd_pkg::EXT_RESET;
            nv1_q    <= flash_cmd_pkg::SR_RESET;
            nv2_q    <= flash_cmd_pkg::SR_RESET;
            nv3_q    <= flash_cmd_pkg::SR_RESET;
            vol1_q   <= flash_cmd_pkg::SR_RESET;
            vol2_q   <= flash_cmd_pkg::SR_RESET;
            vol3_q   <= flash_cmd_pkg::SR_RESET;
        end
        else
        begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            active_q <= active_d;
            wel_q    <= wel_d;
            vol_en_q <= vol_en_d;
            arm_q    <= arm_d;
            addr4_q  <= addr4_d;
            ext_q    <= ext_d;
            nv1_q    <= nv1_d;
            nv2_q    <= nv2_d;
            nv3_q    <= nv3_d;
            vol1_q   <= vol1_d;
            vol2_q   <= vol2_d;
            vol3_q   <= vol3_d;
        end
    end

    always_comb
    begin
        rd1 = vol1_q;
        rd1[flash_cmd_pkg::S1_BUSY] = busy_wr || core_busy_in;
        rd1[flash_cmd_pkg::S1_WREN] = wel_q;
        rd3 = vol3_q;
        rd3[flash_cmd_pkg::S3_ADDR4] = addr4_q;
    end

    // Frozen while a frame is open, so the link side sees a steady word
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            snap1_q    <= flash_cmd_pkg::SR_RESET;
            snap2_q    <= flash_cmd_pkg::SR_RESET;
            snap3_q    <= flash_cmd_pkg::SR_RESET;
            snap_ext_q <= flash_cmd_pkg::EXT_RESET;
            snap_act_q <= 1'b0;
        end
        else if (cs_s2_q)
        begin
            snap1_q    <= rd1;
            snap2_q    <= vol2_q;
            snap3_q    <= rd3;
            snap_ext_q <= ext_q;
            snap_act_q <= active_q;
        end
    end

    assign die_active_out         = active_q;
    assign write_enable_latch_out = wel_q;
    assign busy_out               = rd1[flash_cmd_pkg::S1_BUSY];
    assign addr_4byte_out         = addr4_q;
    assign ext_addr_used_out      = !addr4_q;
    assign ext_addr_out           = ext_q;
    assign status_1_out           = rd1;
    assign status_2_out           = vol2_q;
    assign status_3_out           = rd3;

    default clocking dc @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_nv_start;
        nv_go && !reset_any;
    endsequence

    sequence s_nv_hold;
        busy_wr [*8];
    endsequence

    chk_wel_set: assert property (wren_hit && !reset_any |=> wel_q)
        else $error("latch not set by enable");
    chk_wel_clear: assert property (
        wrdis_hit && !wren_hit |=> !wel_q)
        else $error("latch not cleared by disable");
    chk_nv_busy_hold: assert property (
        disable iff (rst_in || hw_rst) s_nv_start |=> s_nv_hold)
        else $error("busy dropped early");
    chk_nv_cycle_len: assert property (
        disable iff (rst_in || hw_rst) s_nv_start |-> ##WSR_DLY wsr_end)
        else $error("write cycle length wrong");
    chk_nv_end_wel: assert property (
        wsr_end && !wren_hit |=> !wel_q && !busy_wr)
        else $error("latch left set after write");
    chk_vol_quiet: assert property (
        vol_go && wr_s1 && !reset_any |=> !busy_wr && !wel_q &&
        ((vol1_q & flash_cmd_pkg::S1_WMASK) ==
         ($past(byte1_q) & flash_cmd_pkg::S1_WMASK)))
        else $error("volatile write wrong");
    chk_ignore_nowel: assert property (
        cmd && is_wsr && !wel_q && !vol_en_q && !reset_any |=>
        $stable(vol1_q) && $stable(vol2_q) && $stable(vol3_q))
        else $error("unlatched write took effect");
    chk_sr2_kept: assert property (
        vol_go && wr_s1 && len_q == flash_cmd_pkg::LEN_ONE &&
        !reset_any |=> $stable(vol2_q))
        else $error("single byte write touched second register");
    chk_otp_sticky: assert property (
        ((lock_vol & $past(lock_vol)) == $past(lock_vol)) &&
        ((lock_nv & $past(lock_nv)) == $past(lock_nv)))
        else $error("lock bit cleared");
    chk_die_select: assert property (
        die_hit |=> active_q == ($past(byte1_q) == DIE_ID))
        else $error("die select wrong");
    chk_ext_reset: assert property (
        reset_any |=> ext_q == flash_cmd_pkg::EXT_RESET)
        else $error("extended address not cleared");
    chk_ext_follow: assert property (
        addr_hit && !reset_any |=> ext_q == $past(byte1_q))
        else $error("extended address not overwritten");

endmodule : flash_die_ctrl

`default_nettype wire

// [include/flash_cmd_pkg.sv]
`default_nettype none

package flash_cmd_pkg;

    // Instruction codes
    localparam logic [7:0] OP_DIE_SEL   = 8'hC2;
    localparam logic [7:0] OP_WR_EN     = 8'h06;
    localparam logic [7:0] OP_WR_DIS    = 8'h04;
    localparam logic [7:0] OP_VOL_EN    = 8'h50;
    localparam logic [7:0] OP_RD_S1     = 8'h05;
    localparam logic [7:0] OP_RD_S2     = 8'h35;
    localparam logic [7:0] OP_RD_S3     = 8'h15;
    localparam logic [7:0] OP_WR_S1     = 8'h01;
    localparam logic [7:0] OP_WR_S2     = 8'h31;
    localparam logic [7:0] OP_WR_S3     = 8'h11;
    localparam logic [7:0] OP_RD_EXT    = 8'hC8;
    localparam logic [7:0] OP_WR_EXT    = 8'hC5;
    localparam logic [7:0] OP_ADDR4_ON  = 8'hB7;
    localparam logic [7:0] OP_ADDR4_OFF = 8'hE9;
    localparam logic [7:0] OP_RST_EN    = 8'h66;
    localparam logic [7:0] OP_RST       = 8'h99;

    // Frame lengths in clocked bits
    localparam logic [4:0] LEN_OP       = 5'h08;
    localparam logic [4:0] LEN_ONE      = 5'h10;
    localparam logic [4:0] LEN_TWO      = 5'h18;
    localparam logic [2:0] PHASE_LAST   = 3'h7;
    localparam logic [1:0] BYTES_MAX    = 2'h3;

    // Status field positions and write masks
    localparam int         S1_BUSY      = 0;
    localparam int         S1_WREN      = 1;
    localparam int         S3_ADDR4     = 0;
    localparam int         S3_PWR_ADDR  = 1;
    localparam logic [7:0] S1_WMASK     = 8'h7C;
    localparam logic [7:0] S2_WMASK     = 8'h79;
    localparam logic [7:0] S2_LOCK_MASK = 8'h38;
    localparam logic [7:0] S3_WMASK     = 8'h66;

    // Reset values
    localparam logic [7:0] SR_RESET     = 8'h00;
    localparam logic [7:0] EXT_RESET    = 8'h00;
    localparam logic [7:0] FIRST_DIE    = 8'h00;

    // Timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int WSR_TIME_NS   = 1000;
    localparam int WSR_CYCLES    = (WSR_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                   (WSR_TIME_NS / CLK_PERIOD_NS);

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b01,
        ST_WRITING = 2'b10
    } wsr_state_type;

    // Instructions that carry a leading address byte
    function automatic logic is_addr_op(input logic [7:0] op);
        return op inside {8'h03, 8'h13, 8'h0B, 8'h0C, 8'h02, 8'h12,
                          8'h32, 8'h34, 8'h20, 8'h21, 8'h52, 8'h5C,
                          8'hD8, 8'hDC, 8'h3B, 8'h3C, 8'h6B, 8'h6C,
                          8'hBB, 8'hBC, 8'hEB, 8'hEC, 8'h3D, 8'h36,
                          8'h39};
    endfunction : is_addr_op

endpackage : flash_cmd_pkg

`default_nettype wire

// [tb/spi_host_model.sv]
`default_nettype none

module spi_host_model (
    output logic           sclk_out,
    output logic           cs_n_out,
    output logic           mosi_out,
    input  wire logic      miso_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        // Late in time zero, so the rising select clears the link counters
        cs_n_out <= 1'b1;
        sclk_out <= 1'b0;
        mosi_out <= 1'b0;
    end

    // Mode 0 frame, MSB first; clock idles low between frames
    // Data line is inverted once released so a stale bit never looks valid
    task automatic xfer(input logic [31:0] tx, input int n,
                        output logic [31:0] rx);
        rx = 32'h0;
        // Odd offset keeps link edges off the system clock edges
        #3;
        cs_n_out <= 1'b0;
        #24;
        for (int i = 0; i < n; i++)
        begin
            mosi_out <= tx[n - 1 - i];
            #24 sclk_out <= 1'b1;
            rx = {rx[30:0], miso_in};
            #24 sclk_out <= 1'b0;
        end
        #24 cs_n_out <= 1'b1;
        mosi_out <= ~mosi_out;
        // Deselect gap well above six system clocks
        #119;
    endtask : xfer
endmodule : spi_host_model

`default_nettype wire

// [tb/flash_die_select_status_ext_addr_tb_top.sv]
`default_nettype none

module flash_die_select_status_ext_addr_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_in = 1'b0;
    logic        rst_in;
    logic        hw_reset_n_in = 1'b1;
    logic        core_busy_in = 1'b0;
    logic        core_done_in = 1'b0;
    logic        sclk, cs_n, mosi, so, so_oe, act, write_enable_latch, busy, a4, used;
    logic [7:0]  ext, s1, s2, s3, v;
    logic [31:0] rx;
    int          fails = 0;
    int          n_compared = 0;

    always #4 clk_in = ~clk_in;

    spi_host_model host (.sclk_out(sclk), .cs_n_out(cs_n),
        // A released data line reads as pulled up
        .mosi_out(mosi), .miso_in(so_oe ? so : 1'b1));

    flash_die_ctrl dut (.clk_in(clk_in), .rst_in(rst_in),
        .hw_reset_n_in(hw_reset_n_in), .sclk_in(sclk), .cs_n_in(cs_n),
        .serial_in(mosi), .core_busy_in(core_busy_in),
        .core_done_in(core_done_in), .so_out(so), .so_oe_out(so_oe),
        .die_active_out(act), .write_enable_latch_out(write_enable_latch),
        .busy_out(busy), .addr_4byte_out(a4), .ext_addr_used_out(used),
        .ext_addr_out(ext), .status_1_out(s1), .status_2_out(s2),
        .status_3_out(s3));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : chk

    task automatic cmd(input logic [31:0] tx, input int n);
        @(posedge clk_in);
        host.xfer(tx, n, rx);
    endtask : cmd

    // Two data bytes, so the repeat of the read byte can be seen
    task automatic rd(input logic [7:0] op);
        @(posedge clk_in);
        host.xfer({8'h00, op, 16'h0000}, 24, rx);
        v = rx[7:0];
    endtask : rd

    task automatic summarize;
        if (fails == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize

    initial
    begin
        #300000;
        fails++;
        summarize();
    end

    initial
    begin
        rst_in <= 1'b1;
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        chk(act, 8'h01);
        chk(s1, 8'h00);
        chk(ext, 8'h00);
        chk(write_enable_latch, 8'h00);
        cmd(32'h06, 8);
        chk(write_enable_latch, 8'h01);
        cmd(32'h04, 8);
        chk(write_enable_latch, 8'h00);
        cmd(32'h06, 8);
        @(posedge clk_in) core_done_in <= 1'b1;
        @(posedge clk_in) core_done_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        chk(write_enable_latch, 8'h00);
        cmd(32'hC5AB, 16);
        chk(ext, 8'h00);
        // Latch first, as an extended address write must
        cmd(32'h06, 8);
        cmd(32'hC5AB, 16);
        chk(ext, 8'hAB);
        rd(8'hC8);
        chk(v, 8'hAB);
        chk(used, 8'h01);
        cmd(32'h06, 8);
        cmd(32'h01FF, 16);
        chk(busy, 8'h01);
        rd(8'h05);
        chk(v[0], 1'b1);
        for (int k = 0; k < 400 && busy !== 1'b0; k++)
            @(negedge clk_in);
        chk(write_enable_latch, 8'h00);
        chk(s1, 8'h7C);
        cmd(32'h50, 8);
        chk(write_enable_latch, 8'h00);
        cmd(32'h31FF, 16);
        chk(busy, 8'h00);
        chk(s2, 8'h79);
        cmd(32'h50, 8);
        cmd(32'h010000, 24);
        chk(s1, 8'h00);
        chk(s2, 8'h38);
        cmd(32'h50, 8);
        cmd(32'h0130, 16);
        rd(8'h05);
        chk(v, 8'h30);
        chk(rx[15:8], 8'h30);
        chk(s2, 8'h38);
        cmd(32'hB7, 8);
        chk(a4, 8'h01);
        chk(used, 8'h00);
        cmd(32'h03550000, 32);
        chk(ext, 8'h55);
        cmd(32'hE9, 8);
        chk(a4, 8'h00);
        rd(8'hC8);
        chk(v, 8'h55);
        @(posedge clk_in) hw_reset_n_in <= 1'b0;
        repeat (5) @(posedge clk_in);
        hw_reset_n_in <= 1'b1;
        repeat (5) @(posedge clk_in);
        chk(ext, 8'h00);
        chk(s1, 8'h7C);
        chk(s2, 8'h38);
        cmd(32'hC201, 16);
        chk(act, 8'h00);
        @(posedge clk_in) core_busy_in <= 1'b1;
        cmd(32'h06, 8);
        chk(write_enable_latch, 8'h00);
        chk(busy, 8'h01);
        @(posedge clk_in) core_busy_in <= 1'b0;
        rd(8'h05);
        chk(v, 8'hFF);
        cmd(32'hC200, 16);
        chk(act, 8'h01);
        cmd(32'h50, 8);
        cmd(32'h11FF, 16);
        chk(s3, 8'h66);
        rd(8'h15);
        chk(v, 8'h66);
        rd(8'h35);
        chk(v, 8'h38);
        cmd(32'h66, 8);
        cmd(32'h99, 8);
        chk(s3, 8'h00);
        summarize();
    end
endmodule : flash_die_select_status_ext_addr_tb_top

`default_nettype wire
